/* ncr_pkg.sv */
// Function
// RULE1 - Every reply carries main code and subcode bytes; success gives zero in both.
// RULE2 - Read of protected program region refused with 20/02.
// RULE3 - Read of absent or invalid registered table refused with 20/03.
// RULE4 - Write to read-only or write-protected area refused with 21/01, memory unchanged.
// RULE5 - Write to protected program region refused 21/02 until protect-clear accepted.
// RULE6 - Command not allowed while executing refused with 22/01.
// RULE7 - Command not allowed while stopped refused with 22/02.
// RULE8 - Command forbidden in current mode gives 22 and 03/04/05/06 by mode.
// RULE9 - Control-node-only command sent to another node refused with 22/07.
// RULE10 - Uninstalled hardware gives 23; 02 no file memory, 03 no clock.
// RULE11 - Link start or halt with missing or invalid table refused 24/01.
// RULE12 - Service requested while same service still runs refused with 26/05.
// RULE13 - Link service at a non-member node refused with 26/07.
// RULE14 - Error clear refused 26/0B while cause persists; error stays set.
// RULE15 - Controller-error flags of four nodes at bits 1, 5, 9, 13.
// RULE16 - Communications-error flags of four nodes at bits 2, 6, 10, 14.
// RULE17 - Link-member flags at bits 3, 7, 11, 15; clear means not participating.
// RULE18 - Controller-error flag set on fatal halt or incompatible controller.
// RULE19 - Comms-error flag set on noise, node absent, or cycle time too short.
// RULE20 - Status flags fill sixteen words from the configured first status word; here the words sit at fixed A_STAT0 and stat_base is only stored.
// RULE21 - Bits 0, 4, 8, 12 of each status word are reserved, read zero.
package ncr_pkg;
	localparam logic [7:0] MC_OK      = 8'h00;
	localparam logic [7:0] MC_READ    = 8'h20;
	localparam logic [7:0] MC_WRITE   = 8'h21;
	localparam logic [7:0] MC_MODE    = 8'h22;
	localparam logic [7:0] MC_NOUNIT  = 8'h23;
	localparam logic [7:0] MC_LINK    = 8'h24;
	localparam logic [7:0] MC_CMD     = 8'h26;
	localparam logic [7:0] SC_01      = 8'h01;
	localparam logic [7:0] SC_02      = 8'h02;
	localparam logic [7:0] SC_03      = 8'h03;
	localparam logic [7:0] SC_PROG    = 8'h03;
	localparam logic [7:0] SC_DEBUG   = 8'h04;
	localparam logic [7:0] SC_MON     = 8'h05;
	localparam logic [7:0] SC_RUN     = 8'h06;
	localparam logic [7:0] SC_CTLNODE = 8'h07;
	localparam logic [7:0] SC_BUSY    = 8'h05;
	localparam logic [7:0] SC_NOMEMB  = 8'h07;
	localparam logic [7:0] SC_CAUSE   = 8'h0B;
	localparam int STAT_WORDS   = 16;
	localparam int NODES_PER_WD = 4;
	localparam int BIT_CERR     = 1;
	localparam int BIT_KERR     = 2;
	localparam int BIT_MEMB     = 3;
	// APB map
	localparam logic [11:0] A_CTRL     = 12'h000;
	localparam logic [11:0] A_MODE     = 12'h004;
	localparam logic [11:0] A_RES      = 12'h008;
	localparam logic [11:0] A_CMD      = 12'h00C;
	localparam logic [11:0] A_RESP     = 12'h010;
	localparam logic [11:0] A_STBASE   = 12'h014;
	localparam logic [11:0] A_EVT      = 12'h018;
	localparam logic [11:0] A_STAT0    = 12'h040;
	localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
	localparam logic [31:0] RES_RST    = 32'h0000_0000;
	localparam logic [15:0] STBASE_RST = 16'h0000;

	typedef enum logic [2:0] {
		OP_READ = 3'd0, OP_WRITE = 3'd1, OP_RUNCTL = 3'd2, OP_LINKSS = 3'd3,
		OP_SERVICE = 3'd4, OP_ERRCLR = 3'd5, OP_PCLEAR = 3'd6, OP_MISC = 3'd7
	} ncr_op_t;
	typedef enum logic [1:0] {
		MD_PROG = 2'b00, MD_DEBUG = 2'b01, MD_MON = 2'b11, MD_RUN = 2'b10
	} ncr_mode_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00, ST_EVAL = 2'b01, ST_DONE = 2'b11
	} ncr_st_t;

	// Command word written by software on behalf of a remote node
	typedef struct packed {
		logic [3:0] svc_id;
		logic       need_clock;
		logic       need_fmem;
		logic       ctl_node_only;
		logic       deny_running;
		logic       deny_stopped;
		logic [3:0] deny_modes;
		logic       tgt_table;
		logic       tgt_prog;
		logic       tgt_readonly;
		logic       svc_link;
		ncr_op_t    op;
	} ncr_cmd_t;

	typedef struct packed {
		logic [7:0] main_code;
		logic [7:0] sub_code;
	} ncr_resp_t;

	typedef struct packed {
		ncr_st_t          st;
		ncr_cmd_t         cmd;
		ncr_resp_t        resp;
		logic             prog_prot;
		logic             wr_prot_sw;
		logic             running;
		ncr_mode_t        mode;
		logic             is_ctl_node;
		logic             reg_table_ok;
		logic             link_table_ok;
		logic             fmem_ok;
		logic             clock_ok;
		logic             member;
		logic             err_flag;
		logic             err_cause;
		logic [15:0]      svc_busy;
		logic [15:0]      stat_base;
		logic [15:0]      mem_writes;
		logic [3:0][15:0] cerr;
		logic [3:0][15:0] kerr;
		logic [3:0][15:0] memb;
		logic [31:0]      prdata;
		logic             rd_ack;
	} ncr_state_t;
endpackage : ncr_pkg

/* ncr_core.sv */
`timescale 1ns/1ps
`default_nettype none
module ncr_core
	import ncr_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        nrst_i,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Reply and memory write strobe
	output logic      [15:0] resp_o,
	output logic             resp_valid_o,
	output logic             mem_wr_o
);
	ncr_state_t q, d;
	logic       wr_acc;
	logic       rd_acc;
	logic       mapped;
	logic [3:0] sidx;
	logic [31:0] rd_val;
	logic [15:0] stat_word [STAT_WORDS];
	logic [31:0] sidx_full;
	logic        rd_stall;
	logic        set_prot;
	logic        set_err;
	logic        lack_fmem;
	logic        lack_clock;
	logic        not_ctl_node;
	logic        deny_exec;
	logic        deny_stop;
	logic [3:0]  mode_hit;
	logic [7:0]  mode_sub;
	logic        deny_mode;
	logic        gate_fail;
	ncr_resp_t   gate_resp;
	ncr_resp_t   op_resp;
	ncr_resp_t   verdict;
	logic        accept;

	assign wr_acc = psel_i & penable_i & pwrite_i;
	assign rd_acc = psel_i & penable_i & ~pwrite_i;
	assign sidx_full = (32'(paddr_i) - 32'(A_STAT0)) >> 2;
	assign sidx = sidx_full[3:0];

	// Reads take one wait state: prdata is a flop, so the word is captured in the first
	// access cycle and stands together with pready in the second
	assign rd_stall = rd_acc & ~q.rd_ack;
	// Software sets of protect and error flags; they win over a clear by command
	assign set_prot = wr_acc & (paddr_i == A_CTRL) & pwdata_i[1]; // [RULE5]
	assign set_err  = wr_acc & (paddr_i == A_CTRL) & pwdata_i[7]; // [RULE14]

	// Checks that apply to every command
	assign lack_fmem    = q.cmd.need_fmem & ~q.fmem_ok; // [RULE10]
	assign lack_clock   = q.cmd.need_clock & ~q.clock_ok; // [RULE10]
	assign not_ctl_node = q.cmd.ctl_node_only & ~q.is_ctl_node; // [RULE9]
	assign deny_exec    = q.cmd.deny_running & q.running; // [RULE6]
	assign deny_stop    = q.cmd.deny_stopped & ~q.running; // [RULE7]

	// Status words: four nodes each, reserved bits zero [RULE15] [RULE16] [RULE17] [RULE21]
	genvar w, n;
	generate
		for (w = 0; w < STAT_WORDS; w++) begin : g_word
			for (n = 0; n < NODES_PER_WD; n++) begin : g_node
				assign stat_word[w][4*n]            = 1'b0;
				assign stat_word[w][4*n + BIT_CERR] = q.cerr[n][w];
				assign stat_word[w][4*n + BIT_KERR] = q.kerr[n][w];
				assign stat_word[w][4*n + BIT_MEMB] = q.memb[n][w];
			end
		end
	endgenerate

	always_comb begin
		mapped = 1'b1;
		rd_val = 32'h0000_0000;
		if (paddr_i >= A_STAT0 && paddr_i < A_STAT0 + 12'(4*STAT_WORDS)
		    && paddr_i[1:0] == 2'b00) begin
			rd_val = {16'h0000, stat_word[sidx]}; // [RULE20]
		end else begin
			case (paddr_i)
				A_CTRL:   rd_val = {24'h00_0000, q.err_cause, q.err_flag, q.member,
				                    q.is_ctl_node, q.running, q.wr_prot_sw, q.prog_prot,
				                    1'b0};
				A_MODE:   rd_val = {30'h0000_0000, q.mode};
				A_RES:    rd_val = {16'h0000, q.mem_writes[11:0], q.clock_ok, q.fmem_ok,
				                    q.link_table_ok, q.reg_table_ok};
				A_CMD:    rd_val = {12'h000, q.cmd};
				A_RESP:   rd_val = {14'h0000, q.st, q.resp};
				A_STBASE: rd_val = {q.svc_busy, q.stat_base};
				A_EVT:    rd_val = 32'h0000_0000;
				default: begin
					rd_val = 32'h0000_0000;
					mapped = 1'b0;
				end
			endcase
		end
	end

	// Operating mode to the deny bit that covers it and the subcode that names it
	always_comb begin
		mode_hit = 4'b0000;
		mode_sub = SC_PROG;
		case (q.mode)
			MD_PROG: begin
				mode_hit = 4'b0001;
				mode_sub = SC_PROG;
			end
			MD_DEBUG: begin
				mode_hit = 4'b0010;
				mode_sub = SC_DEBUG;
			end
			MD_MON: begin
				mode_hit = 4'b0100;
				mode_sub = SC_MON;
			end
			MD_RUN: begin
				mode_hit = 4'b1000;
				mode_sub = SC_RUN;
			end
			default: begin
				mode_hit = 4'b0000;
				mode_sub = SC_PROG;
			end
		endcase
	end
	assign deny_mode = |(mode_hit & q.cmd.deny_modes); // [RULE8]

	// Priority: missing hardware, then node role, then run state, then operating mode
	always_comb begin
		gate_fail = 1'b1;
		gate_resp = '{main_code: MC_OK, sub_code: MC_OK};
		if (lack_fmem)
			gate_resp = '{MC_NOUNIT, SC_02}; // [RULE10]
		else if (lack_clock)
			gate_resp = '{MC_NOUNIT, SC_03}; // [RULE10]
		else if (not_ctl_node)
			gate_resp = '{MC_MODE, SC_CTLNODE}; // [RULE9]
		else if (deny_exec)
			gate_resp = '{MC_MODE, SC_01}; // [RULE6]
		else if (deny_stop)
			gate_resp = '{MC_MODE, SC_02}; // [RULE7]
		else if (deny_mode)
			gate_resp = '{MC_MODE, mode_sub}; // [RULE8]
		else
			gate_fail = 1'b0;
	end

	// Checks that depend on the kind of command; consulted only when every gate passed
	always_comb begin
		op_resp = '{main_code: MC_OK, sub_code: MC_OK}; // [RULE1]
		case (q.cmd.op)
			OP_READ: begin
				if (q.cmd.tgt_prog && q.prog_prot)
					op_resp = '{MC_READ, SC_02}; // [RULE2]
				else if (q.cmd.tgt_table && !q.reg_table_ok)
					op_resp = '{MC_READ, SC_03}; // [RULE3]
			end
			OP_WRITE: begin
				// Read-only and the protect switch outrank program protect
				if (q.cmd.tgt_readonly || q.wr_prot_sw)
					op_resp = '{MC_WRITE, SC_01}; // [RULE4]
				else if (q.cmd.tgt_prog && q.prog_prot)
					op_resp = '{MC_WRITE, SC_02}; // [RULE5]
			end
			OP_LINKSS: begin
				if (!q.link_table_ok)
					op_resp = '{MC_LINK, SC_01}; // [RULE11]
			end
			OP_SERVICE: begin
				// Membership first: a busy slot means nothing for a link service at a non-member node
				if (q.cmd.svc_link && !q.member)
					op_resp = '{MC_CMD, SC_NOMEMB}; // [RULE13]
				else if (q.svc_busy[q.cmd.svc_id])
					op_resp = '{MC_CMD, SC_BUSY}; // [RULE12]
			end
			OP_ERRCLR: begin
				if (q.err_cause)
					op_resp = '{MC_CMD, SC_CAUSE}; // [RULE14]
			end
			default: op_resp = '{main_code: MC_OK, sub_code: MC_OK};
		endcase
	end
	assign verdict = gate_fail ? gate_resp : op_resp;
	// Side effects only on success, so a refused command sets nothing but its reply [RULE4]
	assign accept  = (verdict.main_code == MC_OK);

	always_comb begin
		d = q;
		d.rd_ack = rd_stall;
		if (rd_stall)
			d.prdata = rd_val;
		if (wr_acc) begin
			case (paddr_i)
				A_CTRL: begin
					d.wr_prot_sw  = pwdata_i[2];
					d.running     = pwdata_i[3];
					d.is_ctl_node = pwdata_i[4];
					d.member      = pwdata_i[5];
					d.err_cause   = pwdata_i[7];
				end
				A_MODE: d.mode = ncr_mode_t'(pwdata_i[1:0]);
				A_RES: begin
					d.reg_table_ok  = pwdata_i[0];
					d.link_table_ok = pwdata_i[1];
					d.fmem_ok       = pwdata_i[2];
					d.clock_ok      = pwdata_i[3];
				end
				A_CMD: if (q.st == ST_IDLE || q.st == ST_DONE) begin
					d.cmd = ncr_cmd_t'(pwdata_i[19:0]);
					d.st  = ST_EVAL;
				end
				A_STBASE: begin
					d.stat_base = pwdata_i[15:0];
					// Service completion or abort frees the slot
					d.svc_busy  = q.svc_busy & ~pwdata_i[31:16];
				end
				A_EVT: begin
					// [5:2] node, [3:0] of word given in [9:6], event bits [12:10], memb [13]
					for (int k = 0; k < NODES_PER_WD; k++) begin
						if (pwdata_i[2 + k]) begin
							// Clear first, so that a set in the same write wins
							if (pwdata_i[12]) begin
								d.cerr[k][pwdata_i[9:6]] = 1'b0;
								d.kerr[k][pwdata_i[9:6]] = 1'b0;
							end
							if (pwdata_i[10])
								d.cerr[k][pwdata_i[9:6]] = 1'b1; // [RULE18]
							if (pwdata_i[11])
								d.kerr[k][pwdata_i[9:6]] = 1'b1; // [RULE19]
							d.memb[k][pwdata_i[9:6]] = pwdata_i[13]; // [RULE17]
						end
					end
				end
				default: ;
			endcase
		end

		case (q.st)
			ST_IDLE: ;
			ST_EVAL: begin
				d.st   = ST_DONE;
				d.resp = verdict; // [RULE1]
				if (accept) begin
					case (q.cmd.op)
						OP_WRITE:   d.mem_writes = q.mem_writes + 16'h0001; // [RULE4]
						OP_PCLEAR:  d.prog_prot  = 1'b0; // [RULE5]
						OP_SERVICE: d.svc_busy[q.cmd.svc_id] = 1'b1; // [RULE12]
						OP_ERRCLR:  d.err_flag   = 1'b0; // [RULE14]
						default: ;
					endcase
				end
			end
			ST_DONE: ;
			default: d.st = ST_IDLE;
		endcase
		// A set by software in the cycle of a clear by command wins
		if (set_prot)
			d.prog_prot = 1'b1; // [RULE5]
		if (set_err)
			d.err_flag = 1'b1; // [RULE14]
	end

	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			q               <= '0;
			q.st            <= ST_IDLE;
			q.mode          <= MD_PROG;
			q.stat_base     <= STBASE_RST;
		end else begin
			q <= d;
		end
	end

	// Memory write strobe only for accepted writes; refused writes leave memory alone [RULE4]
	assign mem_wr_o     = (q.mem_writes != d.mem_writes);
	assign prdata_o     = q.prdata;
	assign pready_o     = ~rd_stall;
	assign pslverr_o    = psel_i & penable_i & ~mapped;
	assign resp_o       = q.resp;
	assign resp_valid_o = (q.st == ST_DONE);
endmodule : ncr_core
`default_nettype wire

/* ncr_core_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module ncr_core_asserts
	import ncr_pkg::*;
(
	// Watched ports
	input wire logic        clk_sys_i,
	input wire logic        nrst_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic [15:0] resp_o,
	input wire logic        resp_valid_o,
	input wire logic        mem_wr_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	wire logic acc    = psel_i && penable_i && pready_o;
	wire logic cmd_wr = acc && pwrite_i && paddr_i == A_CMD;
	property p_lat; cmd_wr |=> !resp_valid_o ##1 resp_valid_o; endproperty
	property p_wok; mem_wr_o |-> ##1 resp_valid_o && resp_o == 16'h0; endproperty
	property p_wcause; mem_wr_o |-> $past(cmd_wr && pwdata_i[2:0] == 3'd1); endproperty
	property p_pulse; mem_wr_o |=> !mem_wr_o; endproperty
	property p_rsv;
		acc && !pwrite_i && paddr_i[11:6] == 6'h01 |=> (prdata_o & 32'hFFFF_1111) == 32'h0;
	endproperty
	property p_zero; resp_valid_o && resp_o[15:8] == 8'h0 |-> resp_o[7:0] == 8'h0; endproperty
	property p_mode;
		resp_valid_o && resp_o[15:8] == MC_MODE |-> resp_o[7:0] inside {[8'h01:8'h07]};
	endproperty
	property p_hold; resp_valid_o && !cmd_wr |=> resp_valid_o && $stable(resp_o); endproperty
	property p_end; acc && paddr_i == 12'h080 |-> pslverr_o; endproperty
	property p_last; acc && paddr_i == 12'h07C |-> !pslverr_o; endproperty
	a_lat: assert property (p_lat) else $error("reply timing wrong");
	a_wok: assert property (p_wok) else $error("write strobe on refusal");
	a_wcause: assert property (p_wcause) else $error("stray write strobe");
	a_pulse: assert property (p_pulse) else $error("write strobe too long");
	a_rsv: assert property (p_rsv) else $error("reserved status bit set");
	a_zero: assert property (p_zero) else $error("subcode on success");
	a_mode: assert property (p_mode) else $error("mode subcode out of range");
	a_hold: assert property (p_hold) else $error("reply changed");
	a_end: assert property (p_end) else $error("status area too long");
	a_last: assert property (p_last) else $error("status area too short");
	c_cmd: cover property (cmd_wr);
	c_wr: cover property (mem_wr_o);
	c_bad: cover property (acc && pslverr_o);
endmodule : ncr_core_asserts
bind ncr_core ncr_core_asserts chk (.clk_sys_i, .nrst_i, .psel_i, .penable_i, .pwrite_i,
	.paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .resp_o, .resp_valid_o, .mem_wr_o);
`default_nettype wire

/* ncr_remote.sv */
`timescale 1ns/1ps
`default_nettype none
module ncr_remote (
	// Clock
	input  wire logic        clk_sys_i,
	// APB master side
	output logic             psel_o,
	output logic             penable_o,
	output logic             pwrite_o,
	output logic      [11:0] paddr_o,
	output logic      [31:0] pwdata_o,
	input  wire logic [31:0] prdata_i,
	input  wire logic        pready_i
);
	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 12'h0;
		pwdata_o = 32'h0;
	end
	// The slave may insert wait states; read data is taken at the edge that sees pready
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] r);
		psel_o <= 1'b1;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge clk_sys_i);
		penable_o <= 1'b1;
		do @(posedge clk_sys_i); while (pready_i !== 1'b1);
		r = prdata_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		pwdata_o <= ~d;
		@(posedge clk_sys_i);
	endtask : xfer
endmodule : ncr_remote
`default_nettype wire

/* ncr_core_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module ncr_core_bench;
	import ncr_pkg::*;
	logic        clk_sys_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic        psel, penable, pwrite, pready, pslverr, rvalid, memwr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] resp;
	logic [15:0] st [16];
	logic        prot = 1'b0, ef = 1'b0, busy = 1'b0, perr = 1'b0;
	int          num_errors = 0, tests_run = 0, seed = 41, cyc = 0, wcnt = 0, wpulse = 0;
	always #2.5 clk_sys_i = ~clk_sys_i;
	ncr_remote rem (.clk_sys_i, .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
		.paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready));
	ncr_core dut (.clk_sys_i, .nrst_i, .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .resp_o(resp), .resp_valid_o(rvalid), .mem_wr_o(memwr));
	task automatic end_of_test();
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		rem.xfer(1'b1, a, d, r);
	endtask : wr
	task automatic predict(input logic [15:0] c, input logic [7:0] k, input logic [1:0] m,
			input logic [3:0] r, output logic [15:0] e);
		int mi;
		mi = m[1] ? 3 - int'(m[0]) : int'(m[0]);
		e = 16'h0;
		if (c[14] && !r[2]) e = 16'h2302;
		else if (c[15] && !r[3]) e = 16'h2303;
		else if (c[13] && !k[4]) e = 16'h2207;
		else if (c[12] && k[3]) e = 16'h2201;
		else if (c[11] && !k[3]) e = 16'h2202;
		else if (c[7 + mi]) e = {8'h22, 8'(mi + 3)};
		else case (c[2:0])
			3'd0: e = (c[5] && prot) ? 16'h2002 : (c[6] && !r[0]) ? 16'h2003 : 16'h0;
			3'd1: e = (c[4] || k[2]) ? 16'h2101 : (c[5] && prot) ? 16'h2102 : 16'h0;
			3'd3: e = r[1] ? 16'h0 : 16'h2401;
			3'd4: e = (c[3] && !k[5]) ? 16'h2607 : busy ? 16'h2605 : 16'h0;
			3'd5: e = k[7] ? 16'h260B : 16'h0;
			default: e = 16'h0;
		endcase
		if (e == 16'h0 && c[2:0] == 3'd1) wcnt++;
		if (e == 16'h0 && c[2:0] == 3'd4) busy = 1'b1;
		if (e == 16'h0 && c[2:0] == 3'd5) ef = 1'b0;
		if (e == 16'h0 && c[2:0] == 3'd6) prot = 1'b0;
	endtask : predict
	always @(posedge clk_sys_i) begin
		cyc++;
		if (memwr === 1'b1)
			wpulse++;
		if (psel && penable && pready === 1'b1)
			perr = pslverr;
		if (cyc == 30000) begin
			num_errors++;
			end_of_test();
		end
	end
	initial begin
		logic [31:0] d, v;
		logic [15:0] c, e;
		logic [7:0]  k;
		logic [3:0]  r;
		logic [1:0]  m;
		logic        b;
		logic [15:0] base;
		for (int w = 0; w < 16; w++) st[w] = 16'h0;
		repeat (10) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		@(posedge clk_sys_i);
		for (int i = 0; i < 300; i++) begin
			k = 8'($random(seed)) & 8'hFE;
			m = 2'($random(seed));
			r = 4'($random(seed) | $random(seed));
			b = 1'($random(seed));
			c = 16'($random(seed));
			// Sparse deny bits, otherwise nearly every command stops at the early checks
			c[15:7] &= 9'($random(seed) & $random(seed));
			wr(A_CTRL, 32'(k));
			wr(A_MODE, 32'(m));
			wr(A_RES, 32'(r));
			base = 16'($random(seed));
			wr(A_STBASE, {15'h0, b, base});
			prot |= k[1];
			ef |= k[7];
			if (b) busy = 1'b0;
			wr(A_CMD, 32'(c));
			predict(c, k, m, r, e);
			for (int j = 0; j < 8 && rvalid !== 1'b1; j++) @(posedge clk_sys_i);
			chk({15'h0, rvalid, resp}, {15'h0, 1'b1, e});
			rem.xfer(1'b0, A_CTRL, 32'h0, d);
			chk(d & 32'h0000_0042, {25'h0, ef, 4'h0, prot, 1'b0});
		end
		rem.xfer(1'b0, A_RES, 32'h0, d);
		chk(32'(d[15:4]), 32'(wcnt % 4096));
		chk(32'(wpulse), 32'(wcnt));
		rem.xfer(1'b0, A_STBASE, 32'h0, d);
		chk(d, {15'h0, busy, base});
		chk(32'(perr), 32'h0000_0000);
		for (int i = 0; i < 48; i++) begin
			v = 32'($random(seed)) & 32'h0000_3FFC;
			v[9:6] = 4'(i % 16);
			wr(A_EVT, v);
			for (int n = 0; n < 4; n++) if (v[2 + n]) begin
				if (v[12]) st[i % 16][4 * n + 1 +: 2] = 2'b00;
				st[i % 16][4 * n + 1] |= v[10];
				st[i % 16][4 * n + 2] |= v[11];
				st[i % 16][4 * n + 3] = v[13];
			end
			rem.xfer(1'b0, A_STAT0 + 12'(4 * (i % 16)), 32'h0, d);
			chk(d, {16'h0, st[i % 16]});
		end
		rem.xfer(1'b0, 12'h080, 32'h0, d);
		chk(32'(perr), 32'h0000_0001);
		end_of_test();
	end
endmodule : ncr_core_bench
`default_nettype wire
